// file: hw/adc_ctrl.v
// Purpose: register and sequencing logic of a 12-bit SAR converter
// Assumes: AHB-Lite slave, analog core returns its result bits on convData
// Notes: one clock domain; convData is sampled on the last divided tick
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"

// Overview of operation
// [R1] every result, external or internal source, is a 12-bit unsigned value
// [R2] justify 0: high byte holds bits 11..4, low byte bits 3..0 on top
// [R3] justify 1: high byte holds bits 11..8 low, low byte bits 7..0
// [R4] unused result byte positions read as zero
// [R5] with converter disabled, both result bytes keep their contents
// [R6] start bit written high then low begins a conversion
// [R7] busy set when conversion starts, cleared when it completes
// [R8] busy ignores writes; other control fields read/write; reset to zero
// [R9] converter powered only while enable bit is one
// [R10] channel codes 0..7 route channel n, 8..15 select a floating input
// [R11] source field decodes external, supply fractions, amplifier, negative
// [R12] internal source disconnects the external channel input
// [R13] clock field divides system clock by 1 to 128
// [R14] software enables gain amplifier whenever its output is used
// [R15] pin chosen as converter input loses its function and pull-high
// [R16] source/clock register bit 3 reads zero and ignores writes
// [R17] completion also raises the converter interrupt request
// [R18] conversion lasts a fixed count of divided clocks; result before busy
module adc_ctrl #(
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter CHANNELS    = 8
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [11:0] convData,
    output reg         convPowerOn,
    output reg         convSampleClk,
    output reg         convSample,
    output reg  [7:0]  channelRoute,
    output reg         channelFloat,
    output reg  [7:0]  pinAnalogMode,
    output reg  [6:0]  internalRoute,
    output reg         gainAmpOn,
    output reg         bandgapOn,
    output reg         irq
);

    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [7:0]  controlReg;
    reg  [7:0]  sourceClockReg;
    reg  [7:0]  gainRefReg;
    reg  [7:0]  bandgapReg;
    reg  [7:0]  resultLowReg;
    reg  [7:0]  resultHighReg;
    reg  [11:0] resultReg;
    reg         statusReg;
    reg         maskReg;
    reg  [2:0]  stateReg;
    reg  [2:0]  stateNext;
    reg  [6:0]  divCountReg;
    reg  [7:0]  tickCountReg;
    reg         startPrevReg;
    reg         wrPendReg;
    reg  [11:0] wrAddrReg;
    reg  [31:0] rdData;

    wire        enable     = controlReg[`BIT_ENABLE];
    wire [3:0]  channelSel = controlReg[3:0];
    wire [3:0]  sourceSel  = sourceClockReg[7:4];
    wire [2:0]  clockSel   = sourceClockReg[2:0];
    wire        addrPhase  = hsel & htrans[1] & hready;
    wire        startPulse = startPrevReg & ~controlReg[`BIT_START]; // [R6]
    wire [6:0]  divLimit   = (7'h01 << clockSel) - 7'h01;            // [R13]
    wire        divTick    = (divCountReg == divLimit);
    wire        lastTick   = divTick &&
                             (tickCountReg == CONV_CYCLES[7:0] - 8'h01); // [R18]
    wire        convDone   = (stateReg == ST_CONV) & lastTick;
    wire        wrControl  = wrPendReg & (wrAddrReg == `OFS_CONV_CONTROL);
    wire        wrStatus   = wrPendReg & (wrAddrReg == `OFS_IRQ_STATUS);
    // read decode runs on the address phase so data meets its data phase
    wire [11:0] rdAddr     = {haddr[11:2], 2'b00};

    // decode of the source field, used for routing and the external check
    function isExternal;
        input [3:0] sel;
        begin
            isExternal = (sel == 4'h0) | (sel == 4'h4) | (sel[3:2] == 2'b11);
        end
    endfunction

    always @* begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: begin
                if (startPulse && enable) begin
                    stateNext = ST_CONV; // [R7]
                end
            end
            ST_CONV: begin
                if (!enable) begin
                    stateNext = ST_IDLE;
                end else if (lastTick) begin
                    stateNext = ST_DONE;
                end
            end
            ST_DONE: begin
                stateNext = ST_IDLE; // [R18]
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
    end

    always @* begin
        rdData = 32'h00000000;
        if (rdAddr == `OFS_RESULT_LOW) begin
            rdData = {24'h000000, resultLowReg};
        end else if (rdAddr == `OFS_RESULT_HIGH) begin
            rdData = {24'h000000, resultHighReg};
        end else if (rdAddr == `OFS_CONV_CONTROL) begin
            rdData = {24'h000000, controlReg};
        end else if (rdAddr == `OFS_SOURCE_CLOCK) begin
            rdData = {24'h000000, sourceClockReg};
        end else if (rdAddr == `OFS_GAIN_REF) begin
            rdData = {24'h000000, gainRefReg};
        end else if (rdAddr == `OFS_BANDGAP) begin
            rdData = {24'h000000, bandgapReg};
        end else if (rdAddr == `OFS_IRQ_STATUS) begin
            rdData = {31'h00000000, statusReg};
        end else if (rdAddr == `OFS_IRQ_MASK) begin
            rdData = {31'h00000000, maskReg};
        end
    end

    // bus: address phase captured, data phase answered one cycle later
    always @(posedge clk) begin
        if (sys_rst) begin
            wrPendReg <= 1'b0;
            wrAddrReg <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wrPendReg <= addrPhase & hwrite;
                if (addrPhase) begin
                    wrAddrReg <= {haddr[11:2], 2'b00};
                end
            end
            // launched at the address phase edge, stands through data phase
            if (addrPhase && !hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            controlReg     <= `RST_CONTROL;      // [R8]
            sourceClockReg <= `RST_SOURCE_CLOCK; // [R16]
            gainRefReg     <= `RST_GAIN_REF;
            bandgapReg     <= 8'h00;
            maskReg        <= 1'b0;
        end else begin
            if (wrControl) begin
                controlReg[7]   <= hwdata[7];
                controlReg[5:0] <= hwdata[5:0]; // [R8]
            end
            // busy lingers through the done cycle so result bytes lead it
            controlReg[`BIT_BUSY] <= (stateNext != ST_IDLE) |
                (stateReg == ST_DONE); // [R7] [R18]
            if (wrPendReg && wrAddrReg == `OFS_SOURCE_CLOCK) begin
                sourceClockReg <= hwdata[7:0] & `MASK_SOURCE_CLOCK; // [R16]
            end
            if (wrPendReg && wrAddrReg == `OFS_GAIN_REF) begin
                gainRefReg <= hwdata[7:0] & `MASK_GAIN_REF;
            end
            if (wrPendReg && wrAddrReg == `OFS_BANDGAP) begin
                bandgapReg <= hwdata[7:0] & `MASK_BANDGAP;
            end
            if (wrPendReg && wrAddrReg == `OFS_IRQ_MASK) begin
                maskReg <= hwdata[0];
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            stateReg     <= ST_IDLE;
            startPrevReg <= 1'b0;
            divCountReg  <= 7'h00;
            tickCountReg <= 8'h00;
            resultReg    <= 12'h000;
            statusReg    <= 1'b0;
        end else begin
            stateReg     <= stateNext;
            startPrevReg <= controlReg[`BIT_START];
            if (stateReg != ST_CONV || divTick) begin
                divCountReg <= 7'h00;
            end else begin
                divCountReg <= divCountReg + 7'h01;
            end
            if (stateReg != ST_CONV) begin
                tickCountReg <= 8'h00;
            end else if (divTick) begin
                tickCountReg <= tickCountReg + 8'h01;
            end
            if (convDone && enable) begin
                resultReg <= convData; // [R1]
            end
            // a new event wins over a clear in the same cycle
            if (convDone) begin
                statusReg <= 1'b1; // [R17]
            end else if (wrStatus && hwdata[0]) begin
                statusReg <= 1'b0;
            end
        end
    end

    // result bytes only follow while enabled; disabled they hold
    always @(posedge clk) begin
        if (sys_rst) begin
            resultLowReg  <= 8'h00;
            resultHighReg <= 8'h00;
        end else if (enable) begin // [R5]
            if (controlReg[`BIT_JUSTIFY]) begin
                resultHighReg <= {4'h0, resultReg[11:8]}; // [R3] [R4]
                resultLowReg  <= resultReg[7:0];          // [R3]
            end else begin
                resultHighReg <= resultReg[11:4];          // [R2]
                resultLowReg  <= {resultReg[3:0], 4'h0};   // [R2] [R4]
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : g_route
            always @(posedge clk) begin
                if (sys_rst) begin
                    channelRoute[i]  <= 1'b0;
                    pinAnalogMode[i] <= 1'b0;
                end else begin
                    channelRoute[i] <= enable & isExternal(sourceSel) &
                        (channelSel == i); // [R10] [R12]
                    // pin function and pull-high removed when selected
                    pinAnalogMode[i] <= enable & isExternal(sourceSel) &
                        (channelSel == i); // [R15]
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (sys_rst) begin
            convPowerOn   <= 1'b0;
            convSampleClk <= 1'b0;
            convSample    <= 1'b0;
            channelFloat  <= 1'b0;
            internalRoute <= 7'h00;
            gainAmpOn     <= 1'b0;
            bandgapOn     <= 1'b0;
            irq           <= 1'b0;
        end else begin
            convPowerOn   <= enable; // [R9]
            convSampleClk <= (stateReg == ST_CONV) & divTick &
                enable; // [R13] [R9]
            convSample    <= (stateNext == ST_CONV) & (stateReg == ST_IDLE);
            channelFloat  <= isExternal(sourceSel) & channelSel[3]; // [R10]
            internalRoute <= 7'h00;
            if (!isExternal(sourceSel)) begin
                if (sourceSel[3]) begin
                    internalRoute[6] <= 1'b1; // [R11]
                end else begin
                    internalRoute[(sourceSel[2] ? 3'h3 : 3'h0) +
                        {1'b0, sourceSel[1:0]} - 3'h1] <= 1'b1; // [R11]
                end
            end
            // amplifier follows software; it is not forced on
            gainAmpOn     <= gainRefReg[7]; // [R14]
            bandgapOn     <= bandgapReg[0];
            irq           <= statusReg & maskReg;
        end
    end

endmodule // adc_ctrl

// file: hw/adc_ctrl_regs.vh
// Purpose: offsets, field positions, reset values and counts for adc_ctrl
// Assumes: AHB-Lite byte addresses, one aligned word per register
// Notes: offsets chosen for this block
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define OFS_RESULT_LOW      12'h000
`define OFS_RESULT_HIGH     12'h004
`define OFS_CONV_CONTROL    12'h008
`define OFS_SOURCE_CLOCK    12'h00C
`define OFS_GAIN_REF        12'h010
`define OFS_BANDGAP         12'h014
`define OFS_IRQ_STATUS      12'h018
`define OFS_IRQ_MASK        12'h01C

`define BIT_START           7
`define BIT_BUSY            6
`define BIT_ENABLE          5
`define BIT_JUSTIFY         4
`define RST_CONTROL         8'h00
`define RST_SOURCE_CLOCK    8'h00
`define RST_GAIN_REF        8'h00
`define MASK_SOURCE_CLOCK   8'hF7
`define MASK_GAIN_REF       8'h9F
`define MASK_BANDGAP        8'h01
`define CONV_CYCLES         14

`endif

// file: testbench/adc_ctrl_assertions.sv
// Purpose: port checker for adc_ctrl
// Assumes: one clock, synchronous reset
// Notes: bound to every adc_ctrl instance
`timescale 1ns/10ps
module adc_ctrl_assertions (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        convPowerOn,
    input wire logic        convSampleClk,
    input wire logic        convSample,
    input wire logic [7:0]  channelRoute,
    input wire logic        channelFloat,
    input wire logic [7:0]  pinAnalogMode,
    input wire logic [6:0]  internalRoute
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence rdReq;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence rdSrc;
        rdReq ##0 (haddr == 12'h00C);
    endsequence
    sequence startPulse;
        convSample ##1 !convSample;
    endsequence
    AST_RD_UPPER: assert property (rdReq |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_SRC_BIT3: assert property (rdSrc |=> !hrdata[3])
        else $error("source register bit 3 read as one");
    AST_EXT_OFF: assert property (|internalRoute |-> channelRoute == 8'h0)
        else $error("external channel joined to internal source");
    AST_ONEHOT: assert property ($onehot0(internalRoute)
        && $onehot0(channelRoute)) else $error("route not one-hot");
    AST_FLOAT: assert property (channelFloat |-> !(|channelRoute))
        else $error("floating channel still routed");
    AST_PIN: assert property ((channelRoute & ~pinAnalogMode) == 8'h0)
        else $error("routed pin keeps digital function");
    AST_POWER: assert property (!convPowerOn |-> !convSampleClk
        && channelRoute == 8'h0) else $error("activity while powered off");
    AST_START: assert property (convSample |-> convPowerOn ##0 startPulse)
        else $error("start pulse malformed");
endmodule // adc_ctrl_assertions

bind adc_ctrl adc_ctrl_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .convPowerOn(convPowerOn),
    .convSampleClk(convSampleClk), .convSample(convSample),
    .channelRoute(channelRoute), .channelFloat(channelFloat),
    .pinAnalogMode(pinAnalogMode), .internalRoute(internalRoute));

// file: testbench/adc_core_model.sv
// Purpose: behavioural analog core and input multiplexer
// Assumes: result follows the routed source at once
// Notes: an unrouted input floats, so it changes every cycle
`timescale 1ns/10ps
module adc_core_model (
    input wire logic        clk,
    input wire logic [7:0]  channelRoute,
    input wire logic [6:0]  internalRoute,
    output logic     [11:0] convData
);
    logic [11:0] floatNoise = 12'h5A3;
    always @(posedge clk) floatNoise <= ~floatNoise;
    // pins give 0xC00 plus the one-hot route, internal taps 0xA80 plus it
    assign convData = |channelRoute ? {4'hC, channelRoute}
        : |internalRoute ? {5'h15, internalRoute} : floatNoise;
endmodule // adc_core_model

// file: testbench/tb_adc_ctrl_registers.sv
// Purpose: self-checking bench for adc_ctrl
// Assumes: zero wait state slave, short conversion count
// Notes: hready is looped back from hreadyout
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_adc_ctrl;
    localparam int CONV = 2;
    typedef struct {logic [3:0] src; logic [3:0] ch; logic [11:0] res;} row_t;
    logic        clk = 0, sysRst = 1, hsel = 0, hwrite = 0, rdyS = 0;
    logic [11:0] haddr = 0, convData, d;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, hrdata, rdS = 0, rdata;
    logic [7:0]  channelRoute, pinAnalogMode;
    logic [6:0]  internalRoute;
    logic hreadyout, hresp, convPowerOn, convSampleClk, convSample;
    logic channelFloat, gainAmpOn, bandgapOn, irq;
    int failures = 0, samplesChecked = 0, cyc = 0, pulses = 0, lastP, gap, p0;
    // internal taps are expected at 0xA80 plus the one-hot route
    row_t rows[16] = '{'{0,3,12'hC08}, '{1,0,12'hA81}, '{2,0,12'hA82},
        '{3,0,12'hA84}, '{4,5,12'hC20}, '{5,0,12'hA88}, '{6,0,12'hA90},
        '{7,0,12'hAA0}, '{8,0,12'hAC0}, '{9,0,12'hAC0}, '{10,0,12'hAC0},
        '{11,0,12'hAC0}, '{12,0,12'hC01}, '{13,7,12'hC80},
        '{14,6,12'hC40}, '{15,1,12'hC02}};
    adc_ctrl #(.CONV_CYCLES(CONV), .CHANNELS(8)) u_dut (.clk(clk),
        .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .convData(convData), .convPowerOn(convPowerOn),
        .convSampleClk(convSampleClk), .convSample(convSample),
        .channelRoute(channelRoute), .channelFloat(channelFloat),
        .pinAnalogMode(pinAnalogMode), .internalRoute(internalRoute),
        .gainAmpOn(gainAmpOn), .bandgapOn(bandgapOn), .irq(irq));
    adc_core_model u_core (.clk(clk), .channelRoute(channelRoute),
        .internalRoute(internalRoute), .convData(convData));
    initial begin
        forever #2 clk = ~clk;
    end
    // sampled half a cycle early so the edge never races the slave
    always @(negedge clk) begin
        rdyS <= hreadyout;
        rdS <= hrdata;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convSampleClk === 1'b1) begin
            pulses <= pulses + 1;
            gap <= cyc - lastP;
            lastP <= cyc;
        end
    end
    task automatic print_verdict;
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic waitRdy;
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdyS !== 1'b1 && n < 50);
        if (rdyS !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] v);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        waitRdy();
        htrans <= 2'b00;
        hwdata <= v;
        waitRdy();
        rdata = rdS;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        ahb(1, a, v);
    endtask
    task automatic rd(input logic [11:0] a);
        ahb(0, a, 0);
    endtask
    task automatic wrRd(input logic [11:0] a, input logic [7:0] w, e);
        wr(a, {24'h0, w});
        rd(a);
        `CHK("field", {24'h0, e}, rdata)
    endtask
    task automatic convert(input logic [7:0] ctl, input logic chk);
        int n = 0;
        p0 = pulses;
        wr(`OFS_CONV_CONTROL, {24'h0, ctl | 8'h80});
        rd(`OFS_CONV_CONTROL);
        `CHK("startHigh", {24'h0, ctl | 8'h80}, rdata)
        wr(`OFS_CONV_CONTROL, {24'h0, ctl});
        @(posedge clk);
        do begin
            rd(`OFS_CONV_CONTROL);
            if (n == 0 && chk) `CHK("busy", 1'b1, rdata[6])
            n++;
        end while (rdata[6] && n < 200);
        `CHK("idle", 1'b0, rdata[6])
        if (rdata[6]) print_verdict();
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sysRst <= 0;
        foreach (rows[i]) begin
            d = rows[i].res;
            wr(`OFS_SOURCE_CLOCK, {24'h0, rows[i].src, 1'b0, i[2:0]});
            convert({3'b001, i[0], rows[i].ch}, i[2:0] == 3'h7);
            `CHK("route", d[11:8] == 4'hC ? d[7:0] : 8'h0, channelRoute)
            `CHK("int", d[11:8] == 4'hA ? d[6:0] : 7'h0, internalRoute)
            `CHK("ticks", CONV, pulses - p0)
            `CHK("divide", 1 << i[2:0], gap)
            rd(`OFS_RESULT_HIGH);
            `CHK("high", i[0] ? {28'h0, d[11:8]} : {24'h0, d[11:4]}, rdata)
            rd(`OFS_RESULT_LOW);
            `CHK("low", i[0] ? {24'h0, d[7:0]} : {24'h0, d[3:0], 4'h0}, rdata)
            $display("row %0d done", i);
        end
        convert(8'h01, 0);
        `CHK("ticksOff", p0, pulses)
        `CHK("power", 1'b0, convPowerOn)
        rd(`OFS_RESULT_LOW);
        `CHK("kept", 32'h02, rdata)
        wr(`OFS_SOURCE_CLOCK, 0);
        wrRd(`OFS_CONV_CONTROL, 8'h69, 8'h29);
        `CHK("float", 1'b1, channelFloat)
        wrRd(`OFS_CONV_CONTROL, 8'h5F, 8'h1F);
        wrRd(`OFS_SOURCE_CLOCK, 8'hFF, 8'hF7);
        wrRd(`OFS_GAIN_REF, 8'hFF, 8'h9F);
        wrRd(`OFS_BANDGAP, 8'hFF, 8'h01);
        wrRd(12'h040, 8'hFF, 8'h00);
        `CHK("amp", 2'b11, {gainAmpOn, bandgapOn})
        $display("register test done");
        `CHK("masked", 1'b0, irq)
        wrRd(`OFS_IRQ_STATUS, 8'h00, 8'h01);
        wr(`OFS_IRQ_MASK, 1);
        repeat (2) @(posedge clk);
        `CHK("irqOn", 1'b1, irq)
        wrRd(`OFS_IRQ_STATUS, 8'h01, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("irqOff", 1'b0, irq)
        $display("interrupt test done");
        print_verdict();
    end
endmodule // tb_adc_ctrl
